// ==== pmc_top.sv ====
// multifunction pin configuration: registers, function muxes and pad control
`timescale 1ns/10ps
`default_nettype none
`include "pmc_cfg.svh"

module pmc_top (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // register port
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // control port mode and data
  input wire logic spi_mode_in,
  input wire logic spi_poci_in,
  // settings held elsewhere
  input wire pmc_pkg::pmc_func_e bidir_a_function_in,
  input wire pmc_pkg::pmc_drv_e bidir_a_drive_style_in,
  input wire logic keeper_en_in,
  // routed function signals
  input wire pmc_pkg::pmc_src_t func_src_in,
  // pins
  input wire logic bidir_a_pad_in,
  input wire logic bidir_b_pad_in,
  input wire logic input_only_pad_in,
  output pmc_pkg::pmc_pad_t bidir_a_pad_out,
  output pmc_pkg::pmc_pad_t bidir_b_pad_out,
  output pmc_pkg::pmc_pad_t output_only_pad_out,
  output logic output_pin_keeper_out,
  // decoded inputs
  output logic chip_select_n_out,
  output pmc_pkg::pmc_gpin_t gp_in_out
);
  import pmc_pkg::*;

  // whole module state
  typedef struct packed {
    pmc_func_e bidir_b_function;
    pmc_drv_e bidir_b_drive_style;
    pmc_func_e output_pin_function;
    pmc_drv_e output_pin_drive_style;
    logic input_pin_enable;
    logic bidir_a_out_level;
    logic bidir_b_out_level;
    logic output_pin_level;
    logic [7:0] rdata;
    pmc_pad_t pad_a;
    pmc_pad_t pad_b;
    pmc_pad_t pad_o;
    logic keeper;
    logic cs_n;
    pmc_gpin_t gpin;
  } pmc_st_t;

  pmc_st_t st_ff;
  pmc_st_t nxt_st;
  logic [`PMC_SYNC_W-1:0] sync_lvl;
  logic [2:0] req_lvl;
  pmc_drv_e req_a;
  pmc_drv_e req_b;
  pmc_drv_e req_o;
  pmc_pad_t drv_a;
  pmc_pad_t drv_b;
  pmc_pad_t drv_o;
  logic mon_a;
  logic mon_b;
  logic mon_i;

  // functions that put serial audio on a pin
  function automatic logic is_audio(input pmc_func_e f);
    is_audio = (f inside {PMC_FUNC_PRI_DOUT, PMC_FUNC_PRI_DOUT2, PMC_FUNC_SEC_DOUT,
                          PMC_FUNC_SEC_DOUT2, PMC_FUNC_SEC_BCLK, PMC_FUNC_SEC_FSYNC,
                          PMC_FUNC_MUX_DOUT, PMC_FUNC_DAISY});
  endfunction

  // level that a function puts on its pin
  function automatic logic fn_level(input pmc_func_e f, input logic gpo, input pmc_src_t s);
    fn_level = 1'b0;
    unique case (f)
      PMC_FUNC_GPO: fn_level = gpo;
      PMC_FUNC_IRQ: fn_level = s.irq;
      PMC_FUNC_PDM: fn_level = s.pdm_clock_out;
      PMC_FUNC_PRI_DOUT: fn_level = s.pri_dout;
      PMC_FUNC_PRI_DOUT2: fn_level = s.pri_dout2;
      PMC_FUNC_SEC_DOUT: fn_level = s.sec_dout;
      PMC_FUNC_SEC_DOUT2: fn_level = s.sec_dout2;
      PMC_FUNC_SEC_BCLK: fn_level = s.sec_bclk;
      PMC_FUNC_SEC_FSYNC: fn_level = s.sec_fsync;
      PMC_FUNC_GENERAL_CLOCK_OUTPUT: fn_level = s.general_clock_output;
      PMC_FUNC_MUX_DOUT: fn_level = s.mux_dout;
      PMC_FUNC_DAISY: fn_level = s.daisy_out;
      PMC_FUNC_OFF, PMC_FUNC_GPI, PMC_FUNC_RSV14, PMC_FUNC_RSV15: fn_level = 1'b0;
    endcase
  endfunction

  // drive style that a function asks for
  function automatic pmc_drv_e fn_style(input pmc_func_e f, input pmc_drv_e d);
    if (f inside {PMC_FUNC_OFF, PMC_FUNC_GPI, PMC_FUNC_RSV14, PMC_FUNC_RSV15})
      fn_style = PMC_DRV_HIZ;
    else if (is_audio(f))
      fn_style = PMC_DRV_PUSH_PULL;
    else
      fn_style = d;
  endfunction

  // input levels into the register clock domain
  pmc_sync #(
    .W(`PMC_SYNC_W)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .d_in({bidir_a_pad_in, bidir_b_pad_in, input_only_pad_in}),
    .q_out(sync_lvl)
  );

  // monitor levels, shown only for pins set as general inputs
  always_comb
  begin
    mon_a = sync_lvl[2] & (bidir_a_function_in == PMC_FUNC_GPI);
    mon_b = sync_lvl[1] & (st_ff.bidir_b_function == PMC_FUNC_GPI);
    mon_i = sync_lvl[0] & st_ff.input_pin_enable & ~spi_mode_in;
  end

  // per-pin level and style requests
  always_comb
  begin
    req_lvl[2] = fn_level(bidir_a_function_in, st_ff.bidir_a_out_level, func_src_in);
    req_lvl[1] = fn_level(st_ff.bidir_b_function, st_ff.bidir_b_out_level, func_src_in);
    req_a = fn_style(bidir_a_function_in, bidir_a_drive_style_in);
    req_b = fn_style(st_ff.bidir_b_function, st_ff.bidir_b_drive_style);
    if (spi_mode_in)
    begin
      req_lvl[0] = spi_poci_in;
      req_o = PMC_DRV_PUSH_PULL;
    end
    else
    begin
      req_lvl[0] = fn_level(st_ff.output_pin_function, st_ff.output_pin_level, func_src_in);
      req_o = (st_ff.output_pin_function == PMC_FUNC_GPI) ? PMC_DRV_HIZ :
              fn_style(st_ff.output_pin_function, st_ff.output_pin_drive_style);
    end
  end

  // pad encoders, one per driving pin
  pmc_drive u_drv_a (
    .lvl_in(req_lvl[2]),
    .style_in(req_a),
    .pad_out(drv_a)
  );

  pmc_drive u_drv_b (
    .lvl_in(req_lvl[1]),
    .style_in(req_b),
    .pad_out(drv_b)
  );

  pmc_drive u_drv_o (
    .lvl_in(req_lvl[0]),
    .style_in(req_o),
    .pad_out(drv_o)
  );

  // register writes, reads and pin outputs
  always_comb
  begin
    nxt_st = st_ff;
    if (reg_wr_in)
    begin
      unique case (reg_addr_in)
        `PMC_ADDR_BIDIR_B:
        begin
          nxt_st.bidir_b_function = pmc_func_e'(reg_wdata_in[`PMC_FUNC_MSB:`PMC_FUNC_LSB]);
          nxt_st.bidir_b_drive_style = pmc_drv_e'(reg_wdata_in[`PMC_DRV_MSB:`PMC_DRV_LSB]);
        end
        `PMC_ADDR_OUT_CFG:
        begin
          nxt_st.output_pin_function = pmc_func_e'(reg_wdata_in[`PMC_FUNC_MSB:`PMC_FUNC_LSB]);
          nxt_st.output_pin_drive_style = pmc_drv_e'(reg_wdata_in[`PMC_DRV_MSB:`PMC_DRV_LSB]);
        end
        `PMC_ADDR_IN_CFG: nxt_st.input_pin_enable = reg_wdata_in[`PMC_IN_EN_BIT];
        `PMC_ADDR_VALUE:
        begin
          nxt_st.bidir_a_out_level = reg_wdata_in[`PMC_VAL_A_OUT];
          nxt_st.bidir_b_out_level = reg_wdata_in[`PMC_VAL_B_OUT];
          nxt_st.output_pin_level = reg_wdata_in[`PMC_VAL_O_OUT];
        end
        default: nxt_st.rdata = st_ff.rdata; // unmapped write is dropped
      endcase
    end
    if (reg_rd_in)
    begin
      nxt_st.rdata = 8'h00;
      unique case (reg_addr_in)
        `PMC_ADDR_BIDIR_B:
        begin
          nxt_st.rdata[`PMC_FUNC_MSB:`PMC_FUNC_LSB] = st_ff.bidir_b_function;
          nxt_st.rdata[`PMC_DRV_MSB:`PMC_DRV_LSB] = st_ff.bidir_b_drive_style;
        end
        `PMC_ADDR_OUT_CFG:
        begin
          nxt_st.rdata[`PMC_FUNC_MSB:`PMC_FUNC_LSB] = st_ff.output_pin_function;
          nxt_st.rdata[`PMC_DRV_MSB:`PMC_DRV_LSB] = st_ff.output_pin_drive_style;
        end
        `PMC_ADDR_IN_CFG: nxt_st.rdata[`PMC_IN_EN_BIT] = st_ff.input_pin_enable;
        `PMC_ADDR_VALUE:
        begin
          nxt_st.rdata[`PMC_VAL_A_OUT] = st_ff.bidir_a_out_level;
          nxt_st.rdata[`PMC_VAL_B_OUT] = st_ff.bidir_b_out_level;
          nxt_st.rdata[`PMC_VAL_O_OUT] = st_ff.output_pin_level;
          nxt_st.rdata[`PMC_VAL_A_MON] = mon_a;
          nxt_st.rdata[`PMC_VAL_B_MON] = mon_b;
          nxt_st.rdata[`PMC_VAL_I_MON] = mon_i;
        end
        default: nxt_st.rdata = 8'h00; // unmapped reads as zero
      endcase
    end
    // pins, registered so every output leaves a flop
    nxt_st.pad_a = drv_a;
    nxt_st.pad_b = drv_b;
    nxt_st.pad_o = drv_o;
    nxt_st.keeper = keeper_en_in & ~spi_mode_in & ~is_audio(st_ff.output_pin_function);
    nxt_st.cs_n = spi_mode_in ? sync_lvl[0] : 1'b1;
    nxt_st.gpin.bidir_a = mon_a;
    nxt_st.gpin.bidir_b = mon_b;
    nxt_st.gpin.input_only = mon_i;
  end

  // state register; all fields clear to the register reset values
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // outputs straight from the state flops
  assign reg_rdata_out = st_ff.rdata;
  assign bidir_a_pad_out = st_ff.pad_a;
  assign bidir_b_pad_out = st_ff.pad_b;
  assign output_only_pad_out = st_ff.pad_o;
  assign output_pin_keeper_out = st_ff.keeper;
  assign chip_select_n_out = st_ff.cs_n;
  assign gp_in_out = st_ff.gpin;

endmodule
`default_nettype wire

// ==== pmc_cfg.svh ====
// offsets, field positions and reset values of the pin configuration block
`ifndef PMC_CFG_SVH
`define PMC_CFG_SVH

// register offsets
`define PMC_ADDR_BIDIR_B 8'h0b
`define PMC_ADDR_OUT_CFG 8'h0c
`define PMC_ADDR_IN_CFG 8'h0d
`define PMC_ADDR_VALUE 8'h0e

// reset values
`define PMC_RST_BIDIR_B 8'h00
`define PMC_RST_OUT_CFG 8'h00
`define PMC_RST_IN_CFG 8'h00
`define PMC_RST_VALUE 8'h00

// function and drive fields of the config registers
`define PMC_FUNC_MSB 7
`define PMC_FUNC_LSB 4
`define PMC_DRV_MSB 2
`define PMC_DRV_LSB 0

// input pin enable bit
`define PMC_IN_EN_BIT 1

// value register bit positions
`define PMC_VAL_A_OUT 7
`define PMC_VAL_B_OUT 6
`define PMC_VAL_O_OUT 5
`define PMC_VAL_A_MON 3
`define PMC_VAL_B_MON 2
`define PMC_VAL_I_MON 1

// number of synchronised input pins
`define PMC_SYNC_W 3

`endif

// ==== pmc_pkg.sv ====
// types shared by the pin configuration block
package pmc_pkg;

  // pin function codes
  typedef enum logic [3:0] {
    PMC_FUNC_OFF = 4'h0,
    PMC_FUNC_GPI = 4'h1,
    PMC_FUNC_GPO = 4'h2,
    PMC_FUNC_IRQ = 4'h3,
    PMC_FUNC_PDM = 4'h4,
    PMC_FUNC_PRI_DOUT = 4'h5,
    PMC_FUNC_PRI_DOUT2 = 4'h6,
    PMC_FUNC_SEC_DOUT = 4'h7,
    PMC_FUNC_SEC_DOUT2 = 4'h8,
    PMC_FUNC_SEC_BCLK = 4'h9,
    PMC_FUNC_SEC_FSYNC = 4'ha,
    PMC_FUNC_GENERAL_CLOCK_OUTPUT = 4'hb,
    PMC_FUNC_MUX_DOUT = 4'hc,
    PMC_FUNC_DAISY = 4'hd,
    PMC_FUNC_RSV14 = 4'he,
    PMC_FUNC_RSV15 = 4'hf
  } pmc_func_e;

  // output drive styles
  typedef enum logic [2:0] {
    PMC_DRV_HIZ = 3'h0,
    PMC_DRV_PUSH_PULL = 3'h1,
    PMC_DRV_LOW_WEAK_HIGH = 3'h2,
    PMC_DRV_OPEN_DRAIN = 3'h3,
    PMC_DRV_WEAK_LOW_HIGH = 3'h4,
    PMC_DRV_HIGH_ONLY = 3'h5,
    PMC_DRV_RSV6 = 3'h6,
    PMC_DRV_RSV7 = 3'h7
  } pmc_drv_e;

  // one pad: output level, enable, weak pull-up and pull-down requests
  typedef struct packed {
    logic o;
    logic oe;
    logic pu;
    logic pd;
  } pmc_pad_t;

  // signals of the routed functions that may leave on a pin
  typedef struct packed {
    logic irq;
    logic pdm_clock_out;
    logic pri_dout;
    logic pri_dout2;
    logic sec_dout;
    logic sec_dout2;
    logic sec_bclk;
    logic sec_fsync;
    logic general_clock_output;
    logic mux_dout;
    logic daisy_out;
  } pmc_src_t;

  // synchronised input levels handed to input functions
  typedef struct packed {
    logic bidir_a;
    logic bidir_b;
    logic input_only;
  } pmc_gpin_t;

endpackage

// ==== pmc_sync.sv ====
// two-flop synchroniser for pin levels
`timescale 1ns/10ps
`default_nettype none

module pmc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // levels
  input wire logic [W-1:0] d_in,
  output logic [W-1:0] q_out
);
  import pmc_pkg::*;

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } pmc_sync_st_t;

  pmc_sync_st_t st_ff;
  pmc_sync_st_t nxt_st;

  // first stage feeds only the second
  always_comb
  begin
    nxt_st.s1 = d_in;
    nxt_st.s2 = st_ff.s1;
  end

  // state register
  always_ff @(posedge clk_in)
  begin
    if (rst_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  assign q_out = st_ff.s2;

endmodule
`default_nettype wire

// ==== pmc_drive.sv ====
// turns a level and a drive style into pad controls
`timescale 1ns/10ps
`default_nettype none

module pmc_drive (
  // request
  input wire logic lvl_in,
  input wire pmc_pkg::pmc_drv_e style_in,
  // pad controls
  output pmc_pkg::pmc_pad_t pad_out
);
  import pmc_pkg::*;

  // one case per style; reserved styles leave the pin undriven
  always_comb
  begin
    pad_out = '0;
    unique case (style_in)
      PMC_DRV_HIZ: pad_out = '0;
      PMC_DRV_PUSH_PULL:
      begin
        pad_out.o = lvl_in;
        pad_out.oe = 1'b1;
      end
      PMC_DRV_LOW_WEAK_HIGH:
      begin
        pad_out.oe = ~lvl_in;
        pad_out.pu = lvl_in;
      end
      PMC_DRV_OPEN_DRAIN: pad_out.oe = ~lvl_in;
      PMC_DRV_WEAK_LOW_HIGH:
      begin
        pad_out.o = lvl_in;
        pad_out.oe = lvl_in;
        pad_out.pd = ~lvl_in;
      end
      PMC_DRV_HIGH_ONLY:
      begin
        pad_out.o = lvl_in;
        pad_out.oe = lvl_in;
      end
      PMC_DRV_RSV6, PMC_DRV_RSV7: pad_out = '0;
    endcase
  end

endmodule
`default_nettype wire

// ==== pmc_monitor.sv ====
// assertion checker bound to the pin configuration block
`timescale 1ns/10ps
`default_nettype none
module pmc_monitor (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // watched inputs
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic spi_mode_in,
  input wire logic spi_poci_in,
  input wire logic keeper_en_in,
  input wire logic input_only_pad_in,
  // watched outputs
  input wire logic [7:0] reg_rdata_out,
  input wire pmc_pkg::pmc_pad_t output_only_pad_out,
  input wire logic output_pin_keeper_out,
  input wire logic chip_select_n_out,
  input wire pmc_pkg::pmc_gpin_t gp_in_out
);
  import pmc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  // spi mode hands the output pin to the data-out level
  spi_poci_a: assert property (spi_mode_in |=> output_only_pad_out.oe &&
    output_only_pad_out.o == $past(spi_poci_in)) else $error("spi data out not on pin");
  // chip select follows the synchronised input pin in spi mode
  cs_spi_a: assert property (spi_mode_in [*4] |->
    chip_select_n_out == $past(input_only_pad_in, 3)) else $error("chip select wrong");
  cs_idle_a: assert property (!spi_mode_in [*4] |-> chip_select_n_out)
    else $error("chip select active outside spi");
  spi_gpin_a: assert property (spi_mode_in [*4] |-> !gp_in_out.input_only)
    else $error("input pin enabled in spi mode");
  // keeper only on request
  keeper_req_a: assert property (output_pin_keeper_out |-> $past(keeper_en_in))
    else $error("keeper without request");
  // input level passes the synchroniser first
  gp_sync_a: assert property (gp_in_out.input_only |-> $past(input_only_pad_in, 3))
    else $error("input level not synchronised");
  // reserved bits read as zero
  in_rsv_a: assert property (reg_rd_in && reg_addr_in == 8'h0d |=>
    reg_rdata_out[7:2] == 6'h00 && !reg_rdata_out[0]) else $error("reserved bit set");
  val_rsv_a: assert property (reg_rd_in && reg_addr_in == 8'h0e |=>
    !reg_rdata_out[4] && !reg_rdata_out[0]) else $error("reserved value bit set");
  cfg_rsv_a: assert property (reg_rd_in && reg_addr_in inside {8'h0b, 8'h0c} |=>
    !reg_rdata_out[3]) else $error("reserved config bit set");
endmodule
bind pmc_top pmc_monitor pmc_monitor_i (.clk_in, .rst_in, .reg_rd_in, .reg_addr_in,
  .spi_mode_in, .spi_poci_in, .keeper_en_in, .input_only_pad_in, .reg_rdata_out,
  .output_only_pad_out, .output_pin_keeper_out, .chip_select_n_out, .gp_in_out);
`default_nettype wire

// ==== pmc_board.sv ====
// board model: drives the pins and resolves the shared wire levels
`timescale 1ns/10ps
`default_nettype none
module pmc_board (
  // clock
  input wire logic clk_in,
  // board drive
  input wire logic ext_en_in,
  input wire logic [2:0] ext_lvl_in,
  // device pads
  input wire pmc_pkg::pmc_pad_t pad_a_in,
  input wire pmc_pkg::pmc_pad_t pad_b_in,
  // resolved levels a, b, input pin
  output logic [2:0] lvl_out
);
  import pmc_pkg::*;
  logic tog_ff = 1'b0;
  // a floating wire never settles
  always @(posedge clk_in) tog_ff <= ~tog_ff;
  // device drive wins, then board, then weak pulls
  function automatic logic res(pmc_pad_t p, logic e, logic v, logic t);
    if (p.oe) return p.o;
    if (e) return v;
    if (p.pu) return 1'b1;
    if (p.pd) return 1'b0;
    return t;
  endfunction
  assign lvl_out = {res(pad_a_in, ext_en_in, ext_lvl_in[2], tog_ff),
    res(pad_b_in, ext_en_in, ext_lvl_in[1], tog_ff), ext_en_in ? ext_lvl_in[0] : tog_ff};
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the pin configuration block
`timescale 1ns/10ps
`default_nettype none
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end
module testbench;
  import pmc_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic wr = 0, rd = 0, spi = 0, poci = 0, keep = 0, ext_en = 1, keeper, csn;
  logic [7:0] addr = 0, wdata = 0, rdata;
  logic [2:0] ext = 0, lvl;
  pmc_func_e fa = PMC_FUNC_OFF;
  pmc_drv_e da = PMC_DRV_HIZ;
  pmc_src_t src = '0;
  pmc_pad_t pa, pb, po;
  pmc_gpin_t gp;
  int error_cnt = 0, check_count = 0;
  int regs [int];
  pmc_top pmc_top_i (.clk_in, .rst_in, .reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr),
    .reg_wdata_in(wdata), .reg_rdata_out(rdata), .spi_mode_in(spi), .spi_poci_in(poci),
    .bidir_a_function_in(fa), .bidir_a_drive_style_in(da), .keeper_en_in(keep),
    .func_src_in(src), .bidir_a_pad_in(lvl[2]), .bidir_b_pad_in(lvl[1]),
    .input_only_pad_in(lvl[0]), .bidir_a_pad_out(pa), .bidir_b_pad_out(pb),
    .output_only_pad_out(po), .output_pin_keeper_out(keeper), .chip_select_n_out(csn),
    .gp_in_out(gp));
  pmc_board pmc_board_i (.clk_in, .ext_en_in(ext_en), .ext_lvl_in(ext), .pad_a_in(pa),
    .pad_b_in(pb), .lvl_out(lvl));
  // 40 MHz clock
  always #12.5 clk_in = ~clk_in;
  // writable bits of each register
  function automatic logic [7:0] mask(logic [7:0] a);
    case (a)
      8'h0d: return 8'h02;
      8'h0e: return 8'he0;
      default: return 8'hf7;
    endcase
  endfunction
  // hide the level of a pad that is not driven
  function automatic pmc_pad_t norm(pmc_pad_t p);
    return {p.o & p.oe, p.oe, p.pu, p.pd};
  endfunction
  // expected pad for a function code, drive style and level
  function automatic pmc_pad_t exp_pad(int c, int d, logic v, pmc_src_t s);
    logic l;
    if (c == 2) l = v;
    else if (c > 2 && c < 14) l = s[13-c];
    else return '0;
    if (c inside {[5:10], 12, 13}) d = 1;
    case (d)
      1: return {l, 3'b100};
      2: return l ? 4'b0010 : 4'b0100;
      3: return l ? 4'b0000 : 4'b0100;
      4: return l ? 4'b1100 : 4'b0001;
      5: return l ? 4'b1100 : 4'b0000;
      default: return '0;
    endcase
  endfunction
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_in);
    wr = 1;
    addr = a;
    wdata = d;
    @(negedge clk_in);
    wr = 0;
    if (regs.exists(a)) regs[a] = d & mask(a);
  endtask
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    @(negedge clk_in);
    rd = 1;
    addr = a;
    @(negedge clk_in);
    rd = 0;
    @(negedge clk_in);
    `CHK(rdata, e)
  endtask
  task automatic reset_dut();
    rst_in = 1;
    repeat (5) @(negedge clk_in);
    rst_in = 0;
    foreach (regs[k]) regs[k] = 0;
  endtask
  // one setting of all three pins with random levels and modes
  task automatic step(input int c, input int d);
    logic [7:0] v, w, m;
    v = 8'($urandom);
    w = 8'($urandom);
    spi = (v[4:3] == 2'b00);
    poci = v[2];
    keep = v[1];
    ext = v[7:5];
    src = pmc_src_t'($urandom);
    fa = pmc_func_e'(c);
    da = pmc_drv_e'(d);
    wr_reg(8'h0b, {c[3:0], 1'b0, d[2:0]});
    wr_reg(8'h0c, {c[3:0], 1'b0, d[2:0]});
    wr_reg(8'h0d, {6'h00, v[0], 1'b0});
    wr_reg(8'h0e, {w[7:5], 5'h00});
    repeat (4) @(negedge clk_in);
    `CHK(norm(pa), exp_pad(c, d, w[7], src))
    `CHK(norm(pb), exp_pad(c, d, w[6], src))
    `CHK(norm(po), spi ? pmc_pad_t'({poci, 3'b100}) : exp_pad(c, d, w[5], src))
    if (!spi) `CHK(keeper, keep && !(c inside {[5:10], 12, 13}))
    m = {w[7:5], 1'b0, c == 1 && ext[2], c == 1 && ext[1], v[0] && !spi && ext[0], 1'b0};
    rd_reg(8'h0e, m);
    `CHK(gp, m[3:1])
    `CHK(csn, spi ? ext[0] : 1'b1)
    rd_reg(8'h0d, {6'h00, v[0], 1'b0});
    rd_reg(8'h0c, {c[3:0], 1'b0, d[2:0]});
    rd_reg(8'h0b, {c[3:0], 1'b0, d[2:0]});
  endtask
  task automatic results();
    $display("errors %0d checks %0d", error_cnt, check_count);
    if (error_cnt == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  // main sequence
  initial
  begin
    void'($urandom(32'h2d5e));
    for (int a = 11; a < 15; a++) regs[a] = 0;
    reset_dut();
    foreach (regs[k]) rd_reg(k[7:0], 8'h00);
    wr_reg(8'h0f, 8'hff);
    rd_reg(8'h0f, 8'h00);
    for (int c = 0; c < 16; c++)
      for (int d = 0; d < 8; d++)
        step(c, d);
    reset_dut();
    foreach (regs[k]) rd_reg(k[7:0], 8'h00);
    results();
  end
  // watchdog
  initial
  begin
    repeat (10000) @(posedge clk_in);
    error_cnt++;
    results();
  end
endmodule
`default_nettype wire
